// ==== design/tcs_pkg.sv ====
`default_nettype none
package tcs_pkg;
  localparam int CLK_NS = 10;
  localparam int CHAN_INDEX = 0;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CFGI = 8'h08;
  localparam logic [7:0] A_ECNT = 8'h0C;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MASK_BIT = 1;
  localparam int CFGI_WE_BIT = 31;
  localparam int CFGI_ADDR_LSB = 16;
  localparam int ANA_RST_NS = 500;
  localparam int COD_RST_NS = 200;
  localparam int PLL_LOCK_NS = 1000;
  localparam logic [7:0] ANA_RST_CYC = 8'((ANA_RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] COD_RST_CYC = 8'((COD_RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PLL_LOCK_CYC = 8'((PLL_LOCK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] CFG_LAT_CYC = 2'h2;
  localparam logic [2:0] LB_NEAR_PCS = 3'h1;
  localparam logic [2:0] LB_NEAR_PMA = 3'h2;
  localparam logic [6:0] EQ_MAX = 7'h7F;
  typedef enum logic [1:0] {CF_IDLE = 2'b01, CF_WORK = 2'b10} tcs_cf_e;
  typedef enum logic [3:0] {
    SC_RESET = 4'b0001,
    SC_WAIT = 4'b0010,
    SC_ARMED = 4'b0100,
    SC_COUNT = 4'b1000
  } tcs_sc_e;
endpackage : tcs_pkg
`default_nettype wire

// ==== design/tcs_port.sv ====
`default_nettype none
module tcs_port
  import tcs_pkg::*;
#(
  parameter bit BUNDLE_PRESENT = 1'b1,
  parameter int AW = 9,
  parameter int DW = 16
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration access port, channel 0
  input wire logic [AW-1:0] ch0_cfg_addr,
  input wire logic ch0_cfg_access_en,
  input wire logic ch0_cfg_write_sel,
  input wire logic [DW-1:0] ch0_cfg_wdata,
  output logic [DW-1:0] ch0_cfg_rdata,
  output logic ch0_cfg_done,
  output logic ch0_cfg_in_use,
  // Reset and initialization
  input wire logic ch0_tx_analog_reset_start,
  input wire logic ch0_tx_coding_reset_start,
  input wire logic ch0_rx_analog_reset_start,
  input wire logic ch0_rx_coding_reset_start,
  output logic ch0_tx_init_done,
  output logic ch0_rx_init_done,
  output logic ch0_rx_analog_init_done,
  // Clocking status
  output logic ch0_channel_pll_locked,
  output logic shared_pll_locked,
  output logic ch0_tx_phase_align_done,
  output logic ch0_tx_phase_init_done,
  output logic ch0_tx_delay_soft_reset_done,
  // Eye scan
  input wire logic ch0_scan_trigger,
  input wire logic ch0_scan_reset,
  input wire logic ch0_rx_symbol_error,
  output logic ch0_scan_error_pulse,
  // Serial path and equalizer
  input wire logic [2:0] ch0_rx_clock_divider_sel,
  input wire logic [2:0] ch0_loop_mode_sel,
  input wire logic ch0_rx_invert,
  input wire logic ch0_tx_invert,
  input wire logic ch0_equalizer_path_sel,
  input wire logic ch0_equalizer_reset,
  input wire logic [1:0] ch0_rx_monitor_sel,
  input wire logic ch0_tx_data_in,
  input wire logic ch0_rx_serial_in,
  output logic ch0_tx_serial_out,
  output logic ch0_rx_data_out,
  output logic [6:0] ch0_rx_monitor_bus
);

////////////////////////////////////////////////////////////////////////////////
  // Asynchronous inputs, two flops each
  localparam int SW = 14;
  logic [SW-1:0] sa_r;
  logic [SW-1:0] sb_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_r <= '0;
      sb_r <= '0;
    end else begin
      sa_r <= {ch0_rx_clock_divider_sel, ch0_loop_mode_sel, ch0_rx_serial_in, ch0_equalizer_reset,
               ch0_equalizer_path_sel, ch0_scan_reset, ch0_rx_coding_reset_start,
               ch0_tx_coding_reset_start, ch0_rx_analog_reset_start, ch0_tx_analog_reset_start};
      sb_r <= sa_r;
    end
  end
  wire logic [1:0] ana_go = sb_r[1:0];
  wire logic [1:0] cod_go = sb_r[3:2];
  wire logic scan_rst_s = sb_r[4];
  wire logic eq_sel_s = sb_r[5];
  wire logic eq_rst_s = sb_r[6];
  wire logic rxs_s = sb_r[7];
  wire logic [2:0] loop_s = sb_r[10:8];
  wire logic [2:0] div_s = sb_r[13:11];

////////////////////////////////////////////////////////////////////////////////
  // APB register file
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic perr_r, perr_nxt;
  logic ind_pend_r, ind_pend_nxt;
  logic ind_we_r, ind_we_nxt;
  logic [AW-1:0] ind_addr_r, ind_addr_nxt;
  logic [DW-1:0] ind_wd_r, ind_wd_nxt;
  logic [DW-1:0] ind_rd_r, ind_rd_nxt;
  logic [15:0] ecnt_r, ecnt_nxt;
  logic ind_take;
  logic scan_err_nxt;
  logic pll_lock_r;
  logic [2:0] ph_r;
  wire logic [1:0] done_w;
  wire logic [1:0] adone_w;
  tcs_sc_e sc_r, sc_nxt;
  // Bundle gone when not built, or switched off by software
  wire logic bon = BUNDLE_PRESENT & ctrl_r[CTRL_EN_BIT];
  wire logic [31:0] stat = 32'({bon, sc_r, ch0_cfg_in_use, ph_r, pll_lock_r, adone_w, done_w});

  always_comb begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    perr_nxt = perr_r;
    ind_pend_nxt = ind_pend_r & ~ind_take;
    ind_we_nxt = ind_we_r;
    ind_addr_nxt = ind_addr_r;
    ind_wd_nxt = ind_wd_r;
    ecnt_nxt = ecnt_r;
    // Read data and error are settled in setup so the access can end at once
    if (psel && !penable) begin
      perr_nxt = 1'b0;
      if (paddr == A_CTRL) begin
        prdata_nxt = 32'(ctrl_r);
      end else if (paddr == A_STAT) begin
        prdata_nxt = stat;
      end else if (paddr == A_CFGI) begin
        prdata_nxt = 32'({ind_pend_r, ind_rd_r});
      end else if (paddr == A_ECNT) begin
        prdata_nxt = 32'(ecnt_r);
      end else begin
        prdata_nxt = '0;
        perr_nxt = 1'b1;
      end
    end
    if (psel && penable && pwrite && !perr_r) begin
      if (paddr == A_CTRL) begin
        ctrl_nxt = pwdata[1:0];
      end else if (paddr == A_CFGI && !ind_pend_r) begin
        ind_pend_nxt = 1'b1;
        ind_we_nxt = pwdata[CFGI_WE_BIT];
        ind_addr_nxt = pwdata[CFGI_ADDR_LSB +: AW];
        ind_wd_nxt = pwdata[DW-1:0];
      end else if (paddr == A_ECNT) begin
        ecnt_nxt = '0;
      end
    end
    // A new error outranks a clear in the same cycle
    if (scan_err_nxt) begin
      ecnt_nxt = ecnt_nxt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      prdata_r <= '0;
      perr_r <= 1'b0;
      ind_pend_r <= 1'b0;
      ind_we_r <= 1'b0;
      ind_addr_r <= '0;
      ind_wd_r <= '0;
      ecnt_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      perr_r <= perr_nxt;
      ind_pend_r <= ind_pend_nxt;
      ind_we_r <= ind_we_nxt;
      ind_addr_r <= ind_addr_nxt;
      ind_wd_r <= ind_wd_nxt;
      ecnt_r <= ecnt_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = perr_r;

////////////////////////////////////////////////////////////////////////////////
  // Configuration access engine
  tcs_cf_e cf_r, cf_nxt;
  logic own_r, own_nxt;
  logic we_r, we_nxt;
  logic [AW-1:0] ad_r, ad_nxt;
  logic [DW-1:0] wd_r, wd_nxt;
  logic [1:0] lat_r, lat_nxt;
  logic cdone_r, cdone_nxt;
  logic [DW-1:0] rd_r, rd_nxt;
  logic mem_wr;
  logic [DW-1:0] mem_r [2**AW];
  wire logic user_req = bon & ch0_cfg_access_en & ~ch0_cfg_in_use;

  always_comb begin
    cf_nxt = cf_r;
    own_nxt = own_r;
    we_nxt = we_r;
    ad_nxt = ad_r;
    wd_nxt = wd_r;
    lat_nxt = lat_r;
    rd_nxt = rd_r;
    ind_rd_nxt = ind_rd_r;
    cdone_nxt = 1'b0;
    ind_take = 1'b0;
    mem_wr = 1'b0;
    case (cf_r)
      CF_IDLE: begin
        // Internal access wins a tie; a pending one raises in use, which holds the user request off
        if (user_req) begin
          cf_nxt = CF_WORK;
          own_nxt = 1'b0;
          ad_nxt = ch0_cfg_addr;
          we_nxt = ch0_cfg_write_sel;
          wd_nxt = ch0_cfg_wdata;
          lat_nxt = CFG_LAT_CYC;
        end else if (ind_pend_r) begin
          cf_nxt = CF_WORK;
          own_nxt = 1'b1;
          ind_take = 1'b1;
          ad_nxt = ind_addr_r;
          we_nxt = ind_we_r;
          wd_nxt = ind_wd_r;
          lat_nxt = CFG_LAT_CYC;
        end
      end
      CF_WORK: begin
        if (lat_r != 2'h0) begin
          lat_nxt = lat_r - 2'h1;
        end else begin
          cf_nxt = CF_IDLE;
          mem_wr = we_r;
          if (own_r) begin
            if (!we_r) begin
              ind_rd_nxt = mem_r[ad_r];
            end
          end else begin
            cdone_nxt = 1'b1;
            if (!we_r) begin
              rd_nxt = mem_r[ad_r];
            end
          end
        end
      end
      default: cf_nxt = CF_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf_r <= CF_IDLE;
      own_r <= 1'b0;
      we_r <= 1'b0;
      ad_r <= '0;
      wd_r <= '0;
      lat_r <= 2'h0;
      cdone_r <= 1'b0;
      rd_r <= '0;
      ind_rd_r <= '0;
    end else begin
      cf_r <= cf_nxt;
      own_r <= own_nxt;
      we_r <= we_nxt;
      ad_r <= ad_nxt;
      wd_r <= wd_nxt;
      lat_r <= lat_nxt;
      cdone_r <= cdone_nxt;
      rd_r <= rd_nxt;
      ind_rd_r <= ind_rd_nxt;
    end
  end

  // Cleared at reset so reads never return unknowns; costs a wide reset tree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= '0;
      end
    end else if (mem_wr) begin
      mem_r[ad_r] <= wd_r;
    end
  end
  assign ch0_cfg_rdata = rd_r;
  assign ch0_cfg_done = cdone_r;
  assign ch0_cfg_in_use = ind_pend_r | (cf_r == CF_WORK && own_r);

////////////////////////////////////////////////////////////////////////////////
  // PLL lock and reset sequencing; index 0 transmit, 1 receive
  logic [7:0] pll_cnt_r, pll_cnt_nxt;
  always_comb begin
    pll_cnt_nxt = (pll_cnt_r != 8'h00) ? pll_cnt_r - 8'h01 : pll_cnt_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_cnt_r <= PLL_LOCK_CYC;
      pll_lock_r <= 1'b0;
    end else begin
      pll_cnt_r <= pll_cnt_nxt;
      pll_lock_r <= (pll_cnt_r == 8'h00);
    end
  end
  assign ch0_channel_pll_locked = bon & pll_lock_r;
  assign shared_pll_locked = bon & pll_lock_r;

  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic [7:0] ana_r, ana_nxt;
    logic [7:0] cod_r, cod_nxt;
    logic dn_r, dn_nxt;
    logic adn_r, adn_nxt;
    // Coding-layer countdown only runs once the analog layer is out of reset
    always_comb begin
      ana_nxt = (ana_r != 8'h00) ? ana_r - 8'h01 : ana_r;
      cod_nxt = (ana_r == 8'h00 && cod_r != 8'h00) ? cod_r - 8'h01 : cod_r;
      if (ana_go[d]) begin
        ana_nxt = ANA_RST_CYC;
      end
      if (ana_go[d] || cod_go[d]) begin
        cod_nxt = COD_RST_CYC;
      end
      adn_nxt = bon & pll_lock_r & ~ana_go[d] & (ana_r == 8'h00);
      dn_nxt = adn_nxt & ~cod_go[d] & (cod_r == 8'h00);
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ana_r <= ANA_RST_CYC;
        cod_r <= COD_RST_CYC;
        dn_r <= 1'b0;
        adn_r <= 1'b0;
      end else begin
        ana_r <= ana_nxt;
        cod_r <= cod_nxt;
        dn_r <= dn_nxt;
        adn_r <= adn_nxt;
      end
    end
    assign done_w[d] = dn_r;
    assign adone_w[d] = adn_r;
  end
  assign ch0_tx_init_done = done_w[0];
  assign ch0_rx_init_done = done_w[1];
  assign ch0_rx_analog_init_done = adone_w[1];

  // Transmit alignment steps follow one cycle apart after transmit ready
  logic [2:0] ph_nxt;
  always_comb begin
    ph_nxt = done_w[0] ? {ph_r[1:0], 1'b1} : 3'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_nxt;
    end
  end
  assign ch0_tx_delay_soft_reset_done = ph_r[0];
  assign ch0_tx_phase_init_done = ph_r[1];
  assign ch0_tx_phase_align_done = ph_r[2];

////////////////////////////////////////////////////////////////////////////////
  // Eye scan
  logic serr_r;
  always_comb begin
    sc_nxt = sc_r;
    case (sc_r)
      SC_RESET: if (!scan_rst_s) sc_nxt = SC_WAIT;
      SC_WAIT: if (done_w[1]) sc_nxt = SC_ARMED;
      SC_ARMED: if (bon && ch0_scan_trigger) sc_nxt = SC_COUNT;
      SC_COUNT: if (bon && ch0_scan_trigger) sc_nxt = SC_ARMED;
      default: sc_nxt = SC_RESET;
    endcase
    if (scan_rst_s) begin
      sc_nxt = SC_RESET;
    end
    scan_err_nxt = bon & ch0_rx_symbol_error & ~ctrl_r[CTRL_MASK_BIT]
                 & (sc_r == SC_ARMED || sc_r == SC_COUNT);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_r <= SC_RESET;
      serr_r <= 1'b0;
    end else begin
      sc_r <= sc_nxt;
      serr_r <= scan_err_nxt;
    end
  end
  assign ch0_scan_error_pulse = serr_r;

////////////////////////////////////////////////////////////////////////////////
  // Serial path, loopback, divider and equalizer
  logic txo_r, txo_nxt;
  logic rxd_r, rxd_nxt;
  logic [6:0] div_r, div_nxt;
  logic [6:0] dfe_r, dfe_nxt;
  logic [6:0] lpm_r, lpm_nxt;
  logic [6:0] mon_r, mon_nxt;
  wire logic [6:0] dmask = 7'((8'h01 << div_s) - 8'h01);
  wire logic near = (loop_s == LB_NEAR_PCS) || (loop_s == LB_NEAR_PMA);

  always_comb begin
    txo_nxt = bon & (ch0_tx_data_in ^ ch0_tx_invert);
    div_nxt = div_r + 7'h01;
    rxd_nxt = rxd_r;
    if ((div_r & dmask) == 7'h00) begin
      rxd_nxt = bon & ((near ? txo_r : rxs_s) ^ ch0_rx_invert);
    end
    dfe_nxt = dfe_r;
    lpm_nxt = lpm_r;
    if (eq_rst_s) begin
      dfe_nxt = 7'h00;
      lpm_nxt = 7'h00;
    end else if (!eq_sel_s) begin
      dfe_nxt = (dfe_r != EQ_MAX) ? dfe_r + 7'h01 : dfe_r;
    end else begin
      lpm_nxt = (lpm_r != EQ_MAX) ? lpm_r + 7'h01 : lpm_r;
    end
    case (ch0_rx_monitor_sel)
      2'h0: mon_nxt = eq_sel_s ? lpm_r : dfe_r;
      2'h1: mon_nxt = dfe_r;
      2'h2: mon_nxt = lpm_r;
      default: mon_nxt = {div_s, loop_s, eq_sel_s};
    endcase
    if (!bon) begin
      mon_nxt = 7'h00;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txo_r <= 1'b0;
      rxd_r <= 1'b0;
      div_r <= 7'h00;
      dfe_r <= 7'h00;
      lpm_r <= 7'h00;
      mon_r <= 7'h00;
    end else begin
      txo_r <= txo_nxt;
      rxd_r <= rxd_nxt;
      div_r <= div_nxt;
      dfe_r <= dfe_nxt;
      lpm_r <= lpm_nxt;
      mon_r <= mon_nxt;
    end
  end
  assign ch0_tx_serial_out = txo_r;
  assign ch0_rx_data_out = rxd_r;
  assign ch0_rx_monitor_bus = mon_r;

endmodule : tcs_port
`default_nettype wire

// ==== tb/tcs_port_sva.sv ====
`default_nettype none
module tcs_port_chk #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // Channel 0
  input wire logic [AW-1:0] ch0_cfg_addr,
  input wire logic ch0_cfg_access_en,
  input wire logic [DW-1:0] ch0_cfg_rdata,
  input wire logic ch0_cfg_done,
  input wire logic ch0_tx_analog_reset_start,
  input wire logic ch0_rx_coding_reset_start,
  input wire logic ch0_tx_init_done,
  input wire logic ch0_rx_init_done,
  input wire logic ch0_rx_analog_init_done,
  input wire logic ch0_channel_pll_locked,
  input wire logic ch0_rx_symbol_error,
  input wire logic ch0_scan_error_pulse,
  input wire logic ch0_tx_data_in,
  input wire logic ch0_tx_invert,
  input wire logic ch0_tx_serial_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_done_cause: assert property (ch0_cfg_done |-> $past(ch0_cfg_access_en, 4))
    else $error("done without a request four cycles before");
  chk_done_single: assert property (ch0_cfg_done |=> !ch0_cfg_done)
    else $error("done longer than one cycle");
  chk_rdata_hold: assert property (!$stable(ch0_cfg_rdata) |-> ch0_cfg_done)
    else $error("read data moved without done");
  chk_tx_drop: assert property ($rose(ch0_tx_analog_reset_start) |-> ##[1:4] !ch0_tx_init_done)
    else $error("tx init done kept through reset");
  chk_rx_drop: assert property ($rose(ch0_rx_coding_reset_start) |-> ##[1:4] !ch0_rx_init_done)
    else $error("rx init done kept through reset");
  chk_init_lock: assert property (ch0_tx_init_done |-> $past(ch0_channel_pll_locked))
    else $error("tx init done without lock");
  chk_rx_order: assert property (ch0_rx_init_done |-> ch0_rx_analog_init_done)
    else $error("rx init done before analog done");
  chk_scan_cause: assert property (ch0_scan_error_pulse |-> $past(ch0_rx_symbol_error))
    else $error("scan error pulse without error");
  chk_tx_flip: assert property (ch0_channel_pll_locked && $past(ch0_channel_pll_locked)
    |-> ch0_tx_serial_out == ($past(ch0_tx_data_in) ^ $past(ch0_tx_invert)))
    else $error("tx serial out not data xor invert");
  chk_bus_error: assert property (psel && penable |-> pslverr == ((paddr[1:0] != 2'h0) || (paddr > 8'h0C)))
    else $error("slave error does not match address map");
endmodule : tcs_port_chk

bind tcs_port tcs_port_chk #(.AW(AW), .DW(DW)) u_tcs_port_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pslverr(pslverr),
  .ch0_cfg_addr(ch0_cfg_addr), .ch0_cfg_access_en(ch0_cfg_access_en), .ch0_cfg_rdata(ch0_cfg_rdata),
  .ch0_cfg_done(ch0_cfg_done), .ch0_tx_analog_reset_start(ch0_tx_analog_reset_start),
  .ch0_rx_coding_reset_start(ch0_rx_coding_reset_start), .ch0_tx_init_done(ch0_tx_init_done),
  .ch0_rx_init_done(ch0_rx_init_done), .ch0_rx_analog_init_done(ch0_rx_analog_init_done),
  .ch0_channel_pll_locked(ch0_channel_pll_locked), .ch0_rx_symbol_error(ch0_rx_symbol_error),
  .ch0_scan_error_pulse(ch0_scan_error_pulse), .ch0_tx_data_in(ch0_tx_data_in),
  .ch0_tx_invert(ch0_tx_invert), .ch0_tx_serial_out(ch0_tx_serial_out));
`default_nettype wire

// ==== tb/tcs_fabric_user.sv ====
`default_nettype none
module tcs_fabric_user (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench
  input wire logic go,
  input wire logic go_we,
  input wire logic [8:0] go_addr,
  input wire logic [15:0] go_wdata,
  input wire logic [1:0] go_gap,
  output logic busy,
  // Configuration port
  output logic [8:0] ch0_cfg_addr,
  output logic ch0_cfg_access_en,
  output logic ch0_cfg_write_sel,
  output logic [15:0] ch0_cfg_wdata,
  input wire logic ch0_cfg_done,
  input wire logic ch0_cfg_in_use
);
  logic [1:0] st;
  logic [1:0] gap;
  assign busy = (st != 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= 2'h0;
      gap <= 2'h0;
      ch0_cfg_access_en <= 1'b0;
      ch0_cfg_write_sel <= 1'b0;
      ch0_cfg_addr <= 9'h000;
      ch0_cfg_wdata <= 16'h0000;
    end else begin
      ch0_cfg_access_en <= 1'b0;
      case (st)
        2'h0: if (go) begin
          st <= 2'h1;
          gap <= go_gap;
          ch0_cfg_addr <= go_addr;
          ch0_cfg_write_sel <= go_we;
          ch0_cfg_wdata <= go_wdata;
        end
        2'h1: if (gap != 2'h0) begin
          gap <= gap - 2'h1;
        end else if (!ch0_cfg_in_use) begin
          ch0_cfg_access_en <= 1'b1;
          st <= 2'h2;
        end
        default: begin
          // Fields are garbage once the request has been taken
          ch0_cfg_addr <= ~ch0_cfg_addr;
          ch0_cfg_wdata <= ~ch0_cfg_wdata;
          ch0_cfg_write_sel <= ~ch0_cfg_write_sel;
          if (ch0_cfg_done) st <= 2'h0;
        end
      endcase
    end
  end
endmodule : tcs_fabric_user
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top
  import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] ch0_cfg_addr;
  logic [15:0] ch0_cfg_wdata, ch0_cfg_rdata;
  logic ch0_cfg_access_en, ch0_cfg_write_sel, ch0_cfg_done, ch0_cfg_in_use;
  logic [3:0] rst_st;
  logic ch0_tx_init_done, ch0_rx_init_done, ch0_rx_analog_init_done, ch0_channel_pll_locked, shared_pll_locked;
  logic ch0_tx_phase_align_done, ch0_tx_phase_init_done, ch0_tx_delay_soft_reset_done;
  logic ch0_scan_trigger, ch0_scan_reset, ch0_rx_symbol_error, ch0_scan_error_pulse;
  logic [2:0] ch0_rx_clock_divider_sel, ch0_loop_mode_sel;
  logic ch0_rx_invert, ch0_tx_invert, ch0_equalizer_path_sel, ch0_equalizer_reset;
  logic [1:0] ch0_rx_monitor_sel, go_gap;
  logic ch0_tx_data_in, ch0_rx_serial_in, ch0_tx_serial_out, ch0_rx_data_out;
  logic [6:0] ch0_rx_monitor_bus;
  logic go, go_we, busy, er, b0, b1;
  logic [8:0] go_addr, a;
  logic [15:0] go_wdata, d;
  logic [7:0] ap;
  int n_fail, num_checks, m, k;

  tcs_port u_tcs_port (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ch0_cfg_addr, .ch0_cfg_access_en, .ch0_cfg_write_sel, .ch0_cfg_wdata, .ch0_cfg_rdata, .ch0_cfg_done,
    .ch0_cfg_in_use, .ch0_tx_analog_reset_start(rst_st[0]), .ch0_tx_coding_reset_start(rst_st[1]),
    .ch0_rx_analog_reset_start(rst_st[2]), .ch0_rx_coding_reset_start(rst_st[3]), .ch0_tx_init_done,
    .ch0_rx_init_done, .ch0_rx_analog_init_done, .ch0_channel_pll_locked, .shared_pll_locked,
    .ch0_tx_phase_align_done, .ch0_tx_phase_init_done, .ch0_tx_delay_soft_reset_done, .ch0_scan_trigger,
    .ch0_scan_reset, .ch0_rx_symbol_error, .ch0_scan_error_pulse, .ch0_rx_clock_divider_sel, .ch0_loop_mode_sel,
    .ch0_rx_invert, .ch0_tx_invert, .ch0_equalizer_path_sel, .ch0_equalizer_reset, .ch0_rx_monitor_sel,
    .ch0_tx_data_in, .ch0_rx_serial_in, .ch0_tx_serial_out, .ch0_rx_data_out, .ch0_rx_monitor_bus);
  tcs_fabric_user u_tcs_fabric_user (.pclk, .presetn, .go, .go_we, .go_addr, .go_wdata, .go_gap, .busy,
    .ch0_cfg_addr, .ch0_cfg_access_en, .ch0_cfg_write_sel, .ch0_cfg_wdata, .ch0_cfg_done, .ch0_cfg_in_use);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic w, input logic [8:0] ad, input logic [15:0] wd);
    int i;
    @(posedge pclk);
    go <= 1'b1;
    go_we <= w;
    go_addr <= ad;
    go_wdata <= wd;
    go_gap <= 2'($urandom);
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge pclk);
    chk("cfg busy", 32'h0, {31'h0, busy});
  endtask : cfg
  task automatic wait_init;
    int i;
    for (i = 0; i < 400 && !(ch0_tx_init_done === 1'b1 && ch0_rx_init_done === 1'b1); i++) @(posedge pclk);
    // Phase flags follow init one per edge
    repeat (5) @(posedge pclk);
  endtask : wait_init
  task scan_err(input logic exp);
    @(posedge pclk);
    ch0_rx_symbol_error <= 1'b1;
    @(posedge pclk);
    ch0_rx_symbol_error <= 1'b0;
    #1 chk("scan pulse", {31'h0, exp}, {31'h0, ch0_scan_error_pulse});
  endtask : scan_err
  function logic [31:0] stat_exp(input logic [3:0] sc);
    return 32'h0000_20FF | (32'(sc) << 9);
  endfunction : stat_exp
  function logic [31:0] err_exp(input logic [7:0] ad);
    return {31'h0, (ad[1:0] != 2'h0) || (ad > A_ECNT)};
  endfunction : err_exp
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {n_fail, num_checks} = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, go, go_we, go_addr, go_wdata, go_gap, rst_st} = '0;
    {ch0_scan_trigger, ch0_scan_reset, ch0_rx_symbol_error, ch0_rx_clock_divider_sel, ch0_loop_mode_sel} = '0;
    {ch0_rx_invert, ch0_tx_invert, ch0_equalizer_path_sel, ch0_equalizer_reset, ch0_rx_monitor_sel} = '0;
    {ch0_tx_data_in, ch0_rx_serial_in} = '0;
    void'($urandom(61878));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    wait_init;
    chk("pll lock", 32'h3, {30'h0, ch0_channel_pll_locked, shared_pll_locked});
    chk("phase flags", 32'h7, {29'h0, ch0_tx_phase_align_done, ch0_tx_phase_init_done, ch0_tx_delay_soft_reset_done});
    apb(1'b1, A_STAT, 32'hFFFF_FFFF);
    apb(1'b0, A_STAT, 32'h0);
    chk("status", stat_exp(4'h4), rd);
    for (m = 0; m < 4; m++) begin
      ap = (m == 0) ? 8'h0D : (8'h10 | 8'($urandom));
      apb(1'b0, ap, 32'h0);
      chk("unmapped err", err_exp(ap), {31'h0, er});
      chk("unmapped data", 32'h0, rd);
    end
    // Bundle switched off goes inert
    apb(1'b1, A_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("off lock", 32'h0, {31'h0, ch0_channel_pll_locked});
    chk("off init", 32'h0, {31'h0, ch0_tx_init_done});
    apb(1'b1, A_CTRL, 32'h1);
    wait_init;
    for (m = 0; m < 8; m++) begin
      a = (m == 0) ? 9'h000 : (m == 1) ? 9'h1FF : 9'($urandom);
      d = 16'($urandom);
      cfg(1'b1, a, d);
      cfg(1'b0, a, 16'h0);
      chk("cfg rdata", {16'h0, d}, {16'h0, ch0_cfg_rdata});
    end
    // Internal write holds the user read off until it has landed
    apb(1'b1, A_CFGI, 32'h8005_A5C3);
    cfg(1'b0, 9'h005, 16'h0);
    chk("in use order", 32'h0000_A5C3, {16'h0, ch0_cfg_rdata});
    apb(1'b1, A_CFGI, 32'h0005_0000);
    for (k = 0; k < 8; k++) begin
      apb(1'b0, A_STAT, 32'h0);
      if (rd[8] === 1'b0) break;
    end
    apb(1'b0, A_CFGI, 32'h0);
    chk("cfgi data", 32'h0000_A5C3, rd);
    for (m = 0; m < 16; m++) begin
      @(posedge pclk);
      b0 = 1'($urandom);
      b1 = 1'($urandom);
      ch0_tx_data_in <= b0;
      ch0_tx_invert <= b1;
      @(posedge pclk);
      #1 chk("tx out", {31'h0, b0 ^ b1}, {31'h0, ch0_tx_serial_out});
    end
    for (m = 0; m < 4; m++) begin
      @(posedge pclk);
      ch0_tx_data_in <= 1'b1;
      ch0_tx_invert <= 1'b0;
      ch0_loop_mode_sel <= (m == 3) ? 3'h0 : 3'(m);
      ch0_rx_invert <= (m == 3);
      repeat (10) @(posedge pclk);
      #1 chk("loop data", {31'h0, m != 0}, {31'h0, ch0_rx_data_out});
    end
    apb(1'b1, A_ECNT, 32'h0);
    scan_err(1'b1);
    apb(1'b0, A_ECNT, 32'h0);
    chk("error count", 32'h1, rd);
    apb(1'b1, A_CTRL, 32'h3);
    scan_err(1'b0);
    apb(1'b1, A_CTRL, 32'h1);
    for (m = 0; m < 2; m++) begin
      @(posedge pclk);
      ch0_scan_trigger <= 1'b1;
      @(posedge pclk);
      ch0_scan_trigger <= 1'b0;
      apb(1'b0, A_STAT, 32'h0);
      chk("scan trigger", stat_exp((m == 0) ? 4'h8 : 4'h4), rd);
    end
    @(posedge pclk);
    ch0_scan_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("scan reset", stat_exp(4'h1), rd);
    ch0_scan_reset <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("scan rearm", stat_exp(4'h4), rd);
    for (m = 0; m < 4; m++) begin
      @(posedge pclk);
      rst_st <= 4'h1 << m;
      repeat (3) @(posedge pclk);
      rst_st <= 4'h0;
      repeat (2) @(posedge pclk);
      #1 chk("init drop", 32'h0, {31'h0, (m < 2) ? ch0_tx_init_done : ch0_rx_init_done});
      chk("analog drop", {31'h0, m != 2}, {31'h0, ch0_rx_analog_init_done});
      wait_init;
      chk("init back", 32'h1, {31'h0, ch0_tx_init_done & ch0_rx_init_done});
    end
    repeat (20) begin
      @(posedge pclk);
      ch0_rx_clock_divider_sel <= 3'($urandom);
      ch0_equalizer_path_sel <= 1'($urandom);
      ch0_equalizer_reset <= 1'($urandom);
      ch0_rx_monitor_sel <= 2'($urandom);
      ch0_rx_serial_in <= 1'($urandom);
    end
    @(posedge pclk);
    ch0_rx_monitor_sel <= 2'h3;
    repeat (4) @(posedge pclk);
    chk("monitor", 32'({ch0_rx_clock_divider_sel, ch0_loop_mode_sel, ch0_equalizer_path_sel}), 32'(ch0_rx_monitor_bus));
    ch0_equalizer_reset <= 1'b1;
    ch0_rx_monitor_sel <= 2'h1;
    repeat (5) @(posedge pclk);
    chk("eq reset", 32'h0, 32'(ch0_rx_monitor_bus));
    close_out;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    close_out;
  end
endmodule : tb_top
`default_nettype wire
